// ===== boot_seq_pkg.sv
// Shared constants and pin carrier for the reset / flash boot sequencer.
// Assumes a 200 MHz core clock and an external SPI serial flash in mode 0.
package boot_seq_pkg;

    // =========================================================
    // Clock and serial clock timing
    // =========================================================
    localparam int CLOCK_MHZ = 200;             // Core clock rate
    localparam int FLASH_SCLK_MAX_MHZ = 25;     // Chosen flash clock, below the flash limit
    // Half period of the flash clock in core cycles, rounded up
    localparam int SCLK_HALF = (CLOCK_MHZ + 2 * FLASH_SCLK_MAX_MHZ - 1) / (2 * FLASH_SCLK_MAX_MHZ);
    localparam int DIV_W = 4;                   // Divider counter width

    // =========================================================
    // Boot read frame
    // =========================================================
    localparam logic [7:0] FLASH_CMD_READ = 8'h03;      // Plain read opcode
    localparam logic [23:0] FLASH_BOOT_ADDR = 24'h000000; // Boot record address
    localparam int HDR_BITS = 32;               // Opcode plus address
    localparam int DATA_BITS = 8;               // One configuration byte
    localparam int FRAME_BITS = HDR_BITS + DATA_BITS;
    localparam int CNT_W = 6;                   // Holds FRAME_BITS
    localparam logic [CNT_W-1:0] LAST_BIT = 6'h27; // FRAME_BITS - 1

    // =========================================================
    // Configuration byte layout
    // =========================================================
    localparam int CFG_SEL0_POS = 0;            // Light select 0 bit
    localparam int CFG_SEL1_POS = 1;            // Light select 1 bit
    localparam logic [7:0] CFG_BLANK = 8'hff;   // Erased flash reads as all ones

    // =========================================================
    // Output pin group, one enable per field
    // =========================================================
    localparam int PIN_COUNT = 7;
    typedef struct packed {
        logic mirror_supply_enable;
        logic light_driver_on;
        logic light_select_0;
        logic light_select_1;
        logic flash_sclk;
        logic flash_mosi;
        logic flash_cs_n;
    } pin_out_t;

    // Sequencer states, Gray coded along wait-shift-done-run
    typedef enum logic [1:0] {
        ST_WAIT = 2'b00,
        ST_SHIFT = 2'b01,
        ST_DONE = 2'b11,
        ST_RUN = 2'b10
    } seq_state_t;

endpackage

// ===== level_sync.sv
// Two flip-flop level synchroniser for pin inputs.
// Assumes inputs are slow levels; a pulse shorter than one cycle can be missed.
`timescale 1ns/1ps

module level_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    // =========================================================
    // Synchroniser stages
    // =========================================================
    logic [WIDTH-1:0] meta_ff; // First stage, read only by the second

    // Two stages per bit; reset parks every line low
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            meta_ff <= '0;
            sync_o <= '0;
        end
        else
        begin
            meta_ff <= async_i;
            sync_o <= meta_ff;
        end
    end

endmodule // level_sync

// ===== reset_hold_flash_boot_seq.sv
// Power-on reset and mirror-hold sequencer with a boot read from serial flash.
// Assumes pin inputs are asynchronous and the testbench resolves enabled pins.
`timescale 1ns/1ps

module reset_hold_flash_boot_seq
    import boot_seq_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic power_on_reset_n_i, // Reset pin, low holds device in reset
    input wire logic mirror_hold_n_i,    // Active-low park request pin
    input wire logic flash_miso_i,       // Serial data from flash
    output pin_out_t pins_o,             // Driven pin levels
    output logic [PIN_COUNT-1:0] pins_oe_o, // High while a pin is driven
    output logic init_done_o,            // One-cycle pulse at end of boot
    output logic init_error_o            // Level, boot record blank
);

    // =========================================================
    // Input synchronisation
    // =========================================================
    logic [2:0] sync_out;   // Synchronised pin levels
    logic por_s;            // Reset pin released
    logic park_n_s;         // Mirror-hold high, normal running
    logic miso_s;           // Flash data in core domain
    logic por_q_ff;         // Delayed copy for edge detect
    logic por_rise;         // Release seen this cycle

    // Every asynchronous pin goes through two flops before use
    level_sync #(.WIDTH(3)) u_sync (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .async_i({power_on_reset_n_i, mirror_hold_n_i, flash_miso_i}),
        .sync_o(sync_out)
    );
    assign por_s = sync_out[2];
    assign park_n_s = sync_out[1];
    assign miso_s = sync_out[0];

    // Edge detector reads only the second stage
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            por_q_ff <= 1'b0;
        else
            por_q_ff <= por_s;
    end
    assign por_rise = por_s & ~por_q_ff;

    // =========================================================
    // Sequencer
    // =========================================================
    seq_state_t state_ff;        // Boot state
    logic [DIV_W-1:0] div_ff;    // Half-period counter
    logic tick;                  // Half period elapsed
    logic sclk_rise;             // Serial clock about to rise
    logic sclk_fall;             // Serial clock about to fall
    logic last_fall;             // Final bit of frame done
    logic [CNT_W-1:0] bit_cnt_ff; // Bits completed
    logic sclk_ff;               // Serial clock level
    logic cs_n_ff;               // Chip select level
    logic [FRAME_BITS-1:0] tx_ff; // Outgoing frame, MSB first
    logic [DATA_BITS-1:0] rx_ff; // Incoming bits
    logic [DATA_BITS-1:0] cfg_ff; // Captured configuration byte

    assign tick = (state_ff == ST_SHIFT) && (div_ff == DIV_W'(SCLK_HALF - 1));
    assign sclk_rise = tick & ~sclk_ff;
    assign sclk_fall = tick & sclk_ff;
    assign last_fall = sclk_fall && (bit_cnt_ff == LAST_BIT);

    // State walk; a low reset pin always returns to wait
    always_ff @(posedge clock_i)
    begin
        if (rst_i || !por_s)
            state_ff <= ST_WAIT;
        else
        begin
            unique case (state_ff)
                ST_WAIT:
                begin
                    if (por_rise)
                        state_ff <= ST_SHIFT;
                end
                ST_SHIFT:
                begin
                    if (last_fall)
                        state_ff <= ST_DONE;
                end
                ST_DONE: state_ff <= ST_RUN;
                ST_RUN: state_ff <= ST_RUN; // Boot runs once per release
            endcase
        end
    end

    // Divider runs only inside the frame
    always_ff @(posedge clock_i)
    begin
        if (rst_i || state_ff != ST_SHIFT || tick)
            div_ff <= '0;
        else
            div_ff <= div_ff + 1'b1;
    end

    // Serial clock idles low, mode 0
    always_ff @(posedge clock_i)
    begin
        if (rst_i || state_ff != ST_SHIFT)
            sclk_ff <= 1'b0;
        else if (tick)
            sclk_ff <= ~sclk_ff;
    end

    // Bit counter advances on each falling serial clock
    always_ff @(posedge clock_i)
    begin
        if (rst_i || state_ff != ST_SHIFT)
            bit_cnt_ff <= '0;
        else if (sclk_fall)
            bit_cnt_ff <= bit_cnt_ff + 1'b1;
    end

    // Chip select framed by release and last bit
    always_ff @(posedge clock_i)
    begin
        if (rst_i || !por_s)
            cs_n_ff <= 1'b1;
        else if (state_ff == ST_WAIT && por_rise)
            cs_n_ff <= 1'b0;
        else if (last_fall)
            cs_n_ff <= 1'b1;
    end

    // Transmit shifter; data bits shift out as zeros
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            tx_ff <= '0;
        else if (state_ff == ST_WAIT && por_rise)
            tx_ff <= {FLASH_CMD_READ, FLASH_BOOT_ADDR, DATA_BITS'(0)};
        else if (sclk_fall)
            tx_ff <= {tx_ff[FRAME_BITS-2:0], 1'b0};
    end

    // Receive on rising serial clock; two-cycle sync lag caps the clock rate
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            rx_ff <= '0;
        else if (sclk_rise)
            rx_ff <= {rx_ff[DATA_BITS-2:0], miso_s};
    end

    // =========================================================
    // Completion and status
    // =========================================================
    logic done_ff;   // Init-done pulse
    logic error_ff;  // Blank boot record

    // Configuration capture at end of frame
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            cfg_ff <= '0;
        else if (state_ff == ST_DONE)
            cfg_ff <= rx_ff;
    end

    // Pulse lasts the single done cycle
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            done_ff <= 1'b0;
        else
            done_ff <= (state_ff == ST_DONE);
    end

    // Error held until the next boot
    always_ff @(posedge clock_i)
    begin
        if (rst_i || state_ff == ST_WAIT)
            error_ff <= 1'b0;
        else if (state_ff == ST_DONE)
            error_ff <= (rx_ff == CFG_BLANK);
    end

    // =========================================================
    // Pin drivers
    // =========================================================
    logic mirror_en_ff;   // Mirror supply enable
    logic driver_on_ff;   // Light driver enable
    logic [1:0] sel_ff;   // Light selects
    logic oe_ff;          // Common enable for the seven pins

    // Parking drops the light and the mirror supply at once
    always_ff @(posedge clock_i)
    begin
        if (rst_i || !por_s || !park_n_s)
        begin
            mirror_en_ff <= 1'b0;
            driver_on_ff <= 1'b0;
            sel_ff <= 2'b00;
        end
        else
        begin
            mirror_en_ff <= 1'b1;
            driver_on_ff <= (state_ff == ST_RUN) && !error_ff;
            sel_ff <= {cfg_ff[CFG_SEL1_POS], cfg_ff[CFG_SEL0_POS]};
        end
    end

    // Pins float while the reset pin is low; external pulls hold them
    always_ff @(posedge clock_i)
    begin
        if (rst_i || !por_s)
            oe_ff <= 1'b0;
        else
            oe_ff <= 1'b1;
    end

    assign pins_o = '{mirror_supply_enable: mirror_en_ff, light_driver_on: driver_on_ff,
                      light_select_0: sel_ff[0], light_select_1: sel_ff[1],
                      flash_sclk: sclk_ff, flash_mosi: tx_ff[FRAME_BITS-1],
                      flash_cs_n: cs_n_ff};
    assign pins_oe_o = {PIN_COUNT{oe_ff}};
    assign init_done_o = done_ff;
    assign init_error_o = error_ff;

    // =========================================================
    // Assertions
    // =========================================================
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    property p_start;
        (state_ff == ST_WAIT) && por_rise |=> (state_ff == ST_SHIFT) && !cs_n_ff;
    endproperty
    a_start: assert property (p_start) else $error("boot did not start");

    property p_hiz;
        !por_s |=> (pins_oe_o == '0);
    endproperty
    a_hiz: assert property (p_hiz) else $error("pin driven in reset");

    property p_park;
        !park_n_s |=> !mirror_en_ff && !driver_on_ff;
    endproperty
    a_park: assert property (p_park) else $error("park ignored");

    property p_sclk_high;
        $rose(sclk_ff) && (state_ff == ST_SHIFT) |-> ##1 (sclk_ff || !por_s)[*3];
    endproperty
    a_sclk_high: assert property (p_sclk_high) else $error("clock high too short");

    property p_cs_frame;
        (state_ff == ST_SHIFT) |-> !cs_n_ff;
    endproperty
    a_cs_frame: assert property (p_cs_frame) else $error("select high in frame");

    property p_cs_idle;
        (state_ff == ST_RUN) |-> cs_n_ff && !sclk_ff;
    endproperty
    a_cs_idle: assert property (p_cs_idle) else $error("select low after boot");

    property p_shift_out;
        sclk_fall && por_s |=> tx_ff == {$past(tx_ff[FRAME_BITS-2:0]), 1'b0};
    endproperty
    a_shift_out: assert property (p_shift_out) else $error("data out not shifted");

    property p_sample;
        sclk_rise |=> rx_ff[0] == $past(miso_s);
    endproperty
    a_sample: assert property (p_sample) else $error("read bit lost");

    property p_done_pulse;
        done_ff |=> !done_ff ##1 !done_ff;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done not a pulse");

    property p_sync_start;
        (state_ff == ST_SHIFT) && ($past(state_ff) == ST_WAIT) |-> $past(por_s) && !$past(por_q_ff);
    endproperty
    a_sync_start: assert property (p_sync_start) else $error("start without sync");
    c_boot: cover property (done_ff && !error_ff);
    c_blank: cover property (done_ff ##1 error_ff);
    c_park: cover property ((state_ff == ST_RUN) && $fell(park_n_s));
endmodule // reset_hold_flash_boot_seq

// ===== dummy_end_marker_not_used.sv
// Spare source slot of the boot sequencer; it holds no logic.
// Assumes nothing of its surroundings.

// ===== flash_model.sv
// Behavioural serial flash that answers one plain read frame.
// Assumes mode 0 and that the bench resolves released pins first.
`timescale 1ns/1ps

module flash_model (
    input wire logic sclk_i,
    input wire logic mosi_i,
    input wire logic cs_n_i,
    input wire logic [7:0] cfg_byte_i,
    output logic miso_o,
    output logic [31:0] hdr_o,
    output logic [5:0] rise_cnt_o
);
    // ==========
    // Frame capture
    initial
    begin
        miso_o = 1'b0;
        hdr_o = 32'h0;
        rise_cnt_o = 6'h0;
    end

    // Selection opens a fresh frame
    always @(negedge cs_n_i)
    begin
        rise_cnt_o = 6'h0;
        hdr_o = 32'h0;
    end

    // Opcode and address taken on rising clock
    always @(posedge sclk_i)
        if (!cs_n_i)
        begin
            if (rise_cnt_o < 6'h20)
                hdr_o = {hdr_o[30:0], mosi_i};
            rise_cnt_o = rise_cnt_o + 6'h1;
        end

    // Byte out MSB first on falling clock; else toggle, so a stale level is never taken
    always @(negedge sclk_i or posedge cs_n_i)
        if (!cs_n_i && rise_cnt_o >= 6'h20 && rise_cnt_o < 6'h28)
            miso_o = cfg_byte_i[6'h27 - rise_cnt_o];
        else
            miso_o = ~miso_o;
endmodule // flash_model

// ===== test_reset_hold_flash_boot_seq.sv
// Self-checking bench for the reset, park and flash boot sequencer.
// Assumes pull-downs on the flash clock and data, a pull-up on select.
`timescale 1ns/1ps

module test_reset_hold_flash_boot_seq;
    import boot_seq_pkg::*;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic por_n = 1'b0;
    logic hold_n = 1'b0;
    logic [7:0] cfg_byte = 8'h00;
    logic miso;
    pin_out_t pins;
    logic [PIN_COUNT-1:0] oe;
    logic done;
    logic err;
    logic [31:0] hdr;
    logic [5:0] rises;
    logic sclk_w;
    logic mosi_w;
    logic cs_w;
    int n_mismatch = 0;
    int total_checks = 0;
    int done_cnt = 0;
    int cs_low_cnt = 0;

    // ==========
    // Clock, pins and instances
    always #2.5 clock_i = ~clock_i;

    // Released pins fall to their pull level
    assign sclk_w = oe[2] ? pins.flash_sclk : 1'b0;
    assign mosi_w = oe[1] ? pins.flash_mosi : 1'b0;
    assign cs_w = oe[0] ? pins.flash_cs_n : 1'b1;

    reset_hold_flash_boot_seq dut (.clock_i(clock_i), .rst_i(rst_i),
        .power_on_reset_n_i(por_n), .mirror_hold_n_i(hold_n), .flash_miso_i(miso),
        .pins_o(pins), .pins_oe_o(oe), .init_done_o(done), .init_error_o(err));

    flash_model model (.sclk_i(sclk_w), .mosi_i(mosi_w), .cs_n_i(cs_w),
        .cfg_byte_i(cfg_byte), .miso_o(miso), .hdr_o(hdr), .rise_cnt_o(rises));

    // Counts done pulses and selected cycles
    always @(posedge clock_i)
    begin
        if (done === 1'b1)
            done_cnt++;
        if (cs_w === 1'b0)
            cs_low_cnt++;
    end

    // ==========
    // Shared tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Sample just after the edge so its updates have landed
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask

    // Bounded wait for the completion pulse
    task automatic wait_done();
        int i;
        for (i = 0; i < 1000 && done !== 1'b1; i++)
            tick(1);
        if (i == 1000)
        begin
            n_mismatch++;
            $display("wrong value init_done expected 1 seen %b", done);
            end_sim();
        end
    endtask

    // ==========
    // Scenarios
    task automatic test_reset_state();
        tick(20);
        check("oe in reset", oe, 7'h00);
        check("select idle", pins.flash_cs_n, 1'b1);
        check("no done", done_cnt, 0);
        $display("test reset state done");
    endtask

    task automatic test_boot(input logic [7:0] cfg, input logic exp_err);
        @(posedge clock_i);
        cfg_byte <= cfg;
        por_n <= 1'b0;
        tick(8);
        check("oe held off", oe, 7'h00);
        done_cnt = 0;
        cs_low_cnt = 0;
        @(posedge clock_i);
        por_n <= 1'b1;
        hold_n <= 1'b1;
        wait_done();
        tick(400);
        check("done pulses", done_cnt, 1);
        check("error flag", err, exp_err);
        check("frame header", hdr, {FLASH_CMD_READ, FLASH_BOOT_ADDR});
        check("clock rises", rises, FRAME_BITS);
        check("select low cycles", cs_low_cnt, 2 * SCLK_HALF * FRAME_BITS);
        check("oe driven", oe, 7'h7f);
        check("supply on", pins.mirror_supply_enable, 1'b1);
        check("driver on", pins.light_driver_on, !exp_err);
        if (!exp_err)
        begin
            check("select 0", pins.light_select_0, cfg[CFG_SEL0_POS]);
            check("select 1", pins.light_select_1, cfg[CFG_SEL1_POS]);
        end
        $display("test boot %h done", cfg);
    endtask

    task automatic test_park();
        @(posedge clock_i);
        hold_n <= 1'b0;
        tick(1);
        check("supply during sync", pins.mirror_supply_enable, 1'b1);
        tick(4);
        check("supply parked", pins.mirror_supply_enable, 1'b0);
        check("driver parked", pins.light_driver_on, 1'b0);
        check("select parked", pins.light_select_0, 1'b0);
        @(posedge clock_i);
        hold_n <= 1'b1;
        tick(5);
        check("supply back", pins.mirror_supply_enable, 1'b1);
        check("driver back", pins.light_driver_on, 1'b1);
        check("select back", pins.light_select_0, 1'b1);
        $display("test park done");
    endtask

    // Reset pin drops in mid-frame
    task automatic test_abort();
        @(posedge clock_i);
        por_n <= 1'b0;
        tick(8);
        done_cnt = 0;
        @(posedge clock_i);
        por_n <= 1'b1;
        tick(100);
        check("frame running", cs_w, 1'b0);
        @(posedge clock_i);
        por_n <= 1'b0;
        tick(1);
        check("oe during sync", oe, 7'h7f);
        tick(3);
        check("abort oe", oe, 7'h00);
        check("abort select", pins.flash_cs_n, 1'b1);
        // Wait past the point where the cut frame would have ended
        tick(400);
        check("no done after abort", done_cnt, 0);
        check("select stays high", cs_w, 1'b1);
        $display("test abort done");
    endtask

    // Host parks the mirrors ahead of power removal
    task automatic test_power_down();
        @(posedge clock_i);
        hold_n <= 1'b0;
        tick(10);
        check("supply before power-off", pins.mirror_supply_enable, 1'b0);
        check("driver before power-off", pins.light_driver_on, 1'b0);
        $display("test power down done");
    endtask

    // ==========
    // Main sequence
    initial
    begin
        repeat (4) @(posedge clock_i);
        rst_i <= 1'b0;
        test_reset_state();
        test_boot(8'h01, 1'b0);
        test_park();
        test_abort();
        test_boot(8'h02, 1'b0);
        test_boot(CFG_BLANK, 1'b1);
        test_power_down();
        end_sim();
    end
endmodule // test_reset_hold_flash_boot_seq
